//--- src/lcdc_consts.svh
// register map, field positions, reset values and timing counts
`ifndef LCDC_CONSTS_SVH
`define LCDC_CONSTS_SVH
`define LCDC_REG_SRST 5'h00
`define LCDC_REG_DEV 5'h01
`define LCDC_REG_DISP1 5'h02
`define LCDC_REG_DISP2 5'h03
`define LCDC_RAM_FIRST 5'h04
`define LCDC_RAM_LAST 5'h17
`define LCDC_PTR_END 5'h18
`define LCDC_RAM_WORDS 20
`define LCDC_SRST_CODE 8'h2C
`define LCDC_FF_LSB 2
`define LCDC_OSC_BIT 1
`define LCDC_COE_BIT 0
`define LCDC_STRONG_DRIVE_SEL_BIT 4
`define LCDC_MUX_LSB 2
`define LCDC_BIAS_BIT 1
`define LCDC_DE_BIT 0
`define LCDC_BL_LSB 1
`define LCDC_INV_BIT 0
`define LCDC_DEV_MASK 8'h0F
`define LCDC_DISP1_MASK 8'h1F
`define LCDC_DISP2_MASK 8'h07
`define LCDC_DEV_RST 8'h04
`define LCDC_DISP1_RST 8'h00
`define LCDC_DISP2_RST 8'h00
`define LCDC_MUX_STATIC 2'h3
`define LCDC_CLK_HZ 250000000
`define LCDC_OSC_HZ 9216
`define LCDC_OSC_HALF_CYC (`LCDC_CLK_HZ / (2 * `LCDC_OSC_HZ))
`define LCDC_FR0_HZ 32
`define LCDC_FR1_HZ 64
`define LCDC_FR2_HZ 96
`define LCDC_FR3_HZ 128
`define LCDC_BL1_MHZ 500
`define LCDC_BL2_MHZ 1000
`define LCDC_BL3_MHZ 2000
`define LCDC_BLINK_TICKS(mhz) ((`LCDC_OSC_HZ * 1000) / (2 * (mhz)))
`define LCDC_POR_WAIT 2'h3
`endif

//--- src/lcdc_ctrl_top.sv
// lcd driver control registers, timebase and display sequencing
// Notes on behaviour
// - frame rate field picks 32, 64, 96 or 128 Hz; 64 Hz default
// - oscillator runs while the oscillator-disable bit is 0
// - clock pin tristated unless clock output enable is set
// - clock driven out has equal high and low times
// - power-down stops the oscillator and leaves the clock pin idle
// - strong_drive_sel bit selects stronger output drive
// - multiplex field picks four, three, two or one backplane
// - display enable bit leaves power-down and drives the display
// - blink field picks off, 0.5, 1 or 2 Hz
// - blink derived from the working clock; display blank in off phase
// - inversion bit picks line or frame alternating polarity
// - power-on reset only acts when its enable pin is high
// - after reset the device stays powered down until enabled
// - power-down keeps register contents and the serial port alive
// - power-on reset clears outputs, pointer and display memory, and loads register defaults
// - without power-on reset, registers count as undefined until soft reset
// - soft reset loads all register defaults, clears display memory and pointer
// - pointer advances per data byte, stops at 18h, later bytes dropped
// - code 2Ch to register zero gives one reset pulse; reads zero
`include "lcdc_consts.svh"
`timescale 1ns/1ps
module lcdc_ctrl_top
  import lcdc_pkg::*;
#(
  parameter int unsigned OSC_HALF_CYC = `LCDC_OSC_HALF_CYC
) (
  // core clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // strap
  input wire logic power_on_reset_enable_pin,
  // serial port
  input wire logic scl,
  input wire logic ce_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  // clock pin
  input wire logic clk_pin_in,
  output logic clk_pin_out,
  output logic clk_pin_oe,
  // display drive
  output logic [3:0] backplane_out,
  output logic [35:0] segment_out,
  output logic strong_drive_active,
  output logic bias_half_active,
  output logic regs_undefined
);
  logic tg_raw;
  lcdc_evt_e evt_kind;
  lcdc_byte_t evt_byte;
  lcdc_byte_t rd_byte_r;
  logic tg_s1_r, tg_s2_r, tg_seen_r, armed_r;
  logic power_on_reset_enable_pin_s1_r, power_on_reset_enable_pin_s2_r;
  logic ck_s1_r, ck_s2_r, ck_s3_r;
  logic fire, wr_en, srst_r, valid_r;
  logic [1:0] por_wait_r;
  logic [4:0] ptr_r;
  lcdc_byte_t dev_r, disp1_r, disp2_r;
  lcdc_byte_t ram_r [`LCDC_RAM_WORDS];
  // settings in force on the outputs
  logic [1:0] ff_a_r, mux_a_r, bl_a_r;
  logic osc_dis_a_r, coe_a_r, strong_drive_sel_a_r, bias_a_r, inv_a_r, run_r;
  logic [15:0] osc_cnt_r;
  logic osc_r, tick;
  logic [11:0] row_cnt_r, row_len;
  logic [1:0] row_r, last_row;
  logic line_par_r, frame_par_r, frame_end, pol;
  logic [13:0] blink_cnt_r, blink_half;
  logic blank_r;
  logic [35:0] row_bits;
  logic [4:0] row_base;

  lcdc_spi_link u_link (
    .scl(scl),
    .ce_n(ce_n),
    .sdio_in(sdio_in),
    .sdio_out(sdio_out),
    .sdio_oe(sdio_oe),
    .evt_toggle(tg_raw),
    .evt_kind(evt_kind),
    .evt_byte(evt_byte),
    .rd_byte(rd_byte_r)
  );

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      power_on_reset_enable_pin_s1_r <= 1'b0;
      power_on_reset_enable_pin_s2_r <= 1'b0;
      ck_s1_r <= 1'b0;
      ck_s2_r <= 1'b0;
      ck_s3_r <= 1'b0;
    end else begin
      power_on_reset_enable_pin_s1_r <= power_on_reset_enable_pin;
      power_on_reset_enable_pin_s2_r <= power_on_reset_enable_pin_s1_r;
      ck_s1_r <= clk_pin_in;
      ck_s2_r <= ck_s1_r;
      ck_s3_r <= ck_s2_r;
    end
  end

  // runs through reset, so a toggle level kept from before reset is no event
  always_ff @(posedge mclk) begin
    tg_s1_r <= tg_raw;
    tg_s2_r <= tg_s1_r;
    tg_seen_r <= tg_s2_r;
    armed_r <= resetn;
  end

  assign fire = armed_r && (tg_s2_r != tg_seen_r);
  // until registers are defined by the strap or a soft reset, only register zero is writable
  assign wr_en = fire && (evt_kind == EVT_WDATA) && (valid_r || ptr_r == `LCDC_REG_SRST);

  // strap is read a few cycles after release, once synchronised
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      por_wait_r <= 2'h0;
      valid_r <= 1'b0;
    end else if (srst_r) begin
      valid_r <= 1'b1;
    end else if (por_wait_r != `LCDC_POR_WAIT) begin
      por_wait_r <= por_wait_r + 2'h1;
      if (por_wait_r == `LCDC_POR_WAIT - 2'h1) begin
        valid_r <= power_on_reset_enable_pin_s2_r;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      regs_undefined <= 1'b1;
    end else begin
      regs_undefined <= ~valid_r;
    end
  end

  // one pulse; register zero itself stores nothing
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      srst_r <= 1'b0;
    end else begin
      srst_r <= wr_en && (ptr_r == `LCDC_REG_SRST) && (evt_byte == `LCDC_SRST_CODE);
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn || srst_r) begin
      ptr_r <= 5'h00;
    end else if (fire) begin
      if (evt_kind == EVT_CMD) begin
        ptr_r <= evt_byte[4:0];
      end else if (ptr_r < `LCDC_PTR_END) begin
        ptr_r <= ptr_r + 5'h01;
      end
    end
  end

  // reserved bits are not stored, they read back as zero
  always_ff @(posedge mclk) begin
    if (!resetn || srst_r) begin
      dev_r <= `LCDC_DEV_RST;
      disp1_r <= `LCDC_DISP1_RST;
      disp2_r <= `LCDC_DISP2_RST;
    end else if (wr_en) begin
      case (ptr_r)
        `LCDC_REG_DEV: dev_r <= evt_byte & `LCDC_DEV_MASK;
        `LCDC_REG_DISP1: disp1_r <= evt_byte & `LCDC_DISP1_MASK;
        `LCDC_REG_DISP2: disp2_r <= evt_byte & `LCDC_DISP2_MASK;
        default: dev_r <= dev_r;
      endcase
    end
  end

  generate
    for (genvar i = 0; i < `LCDC_RAM_WORDS; i++) begin : g_ram
      always_ff @(posedge mclk) begin
        if (!resetn || srst_r) begin
          ram_r[i] <= 8'h00;
        end else if (wr_en && ptr_r == `LCDC_RAM_FIRST + 5'(i)) begin
          ram_r[i] <= evt_byte;
        end
      end
    end
  endgenerate

  // held between link events, so the serial side samples a steady byte
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rd_byte_r <= 8'h00;
    end else if (ptr_r == `LCDC_REG_DEV) begin
      rd_byte_r <= dev_r;
    end else if (ptr_r == `LCDC_REG_DISP1) begin
      rd_byte_r <= disp1_r;
    end else if (ptr_r == `LCDC_REG_DISP2) begin
      rd_byte_r <= disp2_r;
    end else if (ptr_r >= `LCDC_RAM_FIRST && ptr_r <= `LCDC_RAM_LAST) begin
      rd_byte_r <= ram_r[5'(ptr_r - `LCDC_RAM_FIRST)];
    end else begin
      rd_byte_r <= 8'h00;
    end
  end

  // new settings land only between frames, or at once while powered down
  always_ff @(posedge mclk) begin
    if (!resetn || srst_r) begin
      run_r <= 1'b0;
      ff_a_r <= 2'(`LCDC_DEV_RST >> `LCDC_FF_LSB);
      osc_dis_a_r <= 1'b0;
      coe_a_r <= 1'b0;
      strong_drive_sel_a_r <= 1'b0;
      mux_a_r <= 2'h0;
      bias_a_r <= 1'b0;
      bl_a_r <= 2'h0;
      inv_a_r <= 1'b0;
    end else if (!run_r || frame_end) begin
      run_r <= disp1_r[`LCDC_DE_BIT] && valid_r;
      ff_a_r <= dev_r[`LCDC_FF_LSB +: 2];
      osc_dis_a_r <= dev_r[`LCDC_OSC_BIT];
      coe_a_r <= dev_r[`LCDC_COE_BIT];
      strong_drive_sel_a_r <= disp1_r[`LCDC_STRONG_DRIVE_SEL_BIT];
      mux_a_r <= disp1_r[`LCDC_MUX_LSB +: 2];
      bias_a_r <= disp1_r[`LCDC_BIAS_BIT];
      bl_a_r <= disp2_r[`LCDC_BL_LSB +: 2];
      inv_a_r <= disp2_r[`LCDC_INV_BIT];
    end
  end

  // oscillator: equal half periods, stopped when disabled or powered down
  always_ff @(posedge mclk) begin
    if (!resetn || !run_r || osc_dis_a_r) begin
      osc_cnt_r <= 16'h0000;
      osc_r <= 1'b0;
    end else if (osc_cnt_r == 16'(OSC_HALF_CYC - 1)) begin
      osc_cnt_r <= 16'h0000;
      osc_r <= ~osc_r;
    end else begin
      osc_cnt_r <= osc_cnt_r + 16'h0001;
    end
  end

  assign clk_pin_out = osc_r;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      clk_pin_oe <= 1'b0;
    end else begin
      clk_pin_oe <= run_r && !osc_dis_a_r && coe_a_r;
    end
  end

  // working clock: internal rising edge, or pin edge when used as input
  always_comb begin
    tick = 1'b0;
    if (run_r && !osc_dis_a_r) begin
      tick = !osc_r && osc_cnt_r == 16'(OSC_HALF_CYC - 1);
    end else if (run_r && !coe_a_r) begin
      tick = ck_s2_r && !ck_s3_r;
    end
  end

  // ticks per backplane row from frame rate and multiplex
  always_comb begin
    logic [11:0] frame_ticks;
    frame_ticks = 12'h000;
    case (ff_a_r)
      2'h0: frame_ticks = 12'(`LCDC_OSC_HZ / `LCDC_FR0_HZ);
      2'h1: frame_ticks = 12'(`LCDC_OSC_HZ / `LCDC_FR1_HZ);
      2'h2: frame_ticks = 12'(`LCDC_OSC_HZ / `LCDC_FR2_HZ);
      default: frame_ticks = 12'(`LCDC_OSC_HZ / `LCDC_FR3_HZ);
    endcase
    case (mux_a_r)
      2'h0: row_len = frame_ticks / 12'h004;
      2'h1: row_len = frame_ticks / 12'h003;
      2'h2: row_len = frame_ticks / 12'h002;
      default: row_len = frame_ticks;
    endcase
    last_row = 2'h3 - mux_a_r;
  end

  assign frame_end = tick && row_cnt_r == row_len - 12'h001 && row_r == last_row;

  always_ff @(posedge mclk) begin
    if (!resetn || !run_r) begin
      row_cnt_r <= 12'h000;
      row_r <= 2'h0;
      line_par_r <= 1'b0;
      frame_par_r <= 1'b0;
    end else if (tick) begin
      if (row_cnt_r == row_len - 12'h001) begin
        row_cnt_r <= 12'h000;
        line_par_r <= ~line_par_r;
        if (row_r == last_row) begin
          row_r <= 2'h0;
          frame_par_r <= ~frame_par_r;
        end else begin
          row_r <= row_r + 2'h1;
        end
      end else begin
        row_cnt_r <= row_cnt_r + 12'h001;
      end
    end
  end

  always_comb begin
    blink_half = 14'h0000;
    case (bl_a_r)
      2'h1: blink_half = 14'(`LCDC_BLINK_TICKS(`LCDC_BL1_MHZ));
      2'h2: blink_half = 14'(`LCDC_BLINK_TICKS(`LCDC_BL2_MHZ));
      2'h3: blink_half = 14'(`LCDC_BLINK_TICKS(`LCDC_BL3_MHZ));
      default: blink_half = 14'h0000;
    endcase
  end

  // blink counts working clock ticks, so it follows an external clock too
  always_ff @(posedge mclk) begin
    if (!resetn || !run_r || bl_a_r == 2'h0) begin
      blink_cnt_r <= 14'h0000;
      blank_r <= 1'b0;
    end else if (tick) begin
      if (blink_cnt_r == blink_half - 14'h0001) begin
        blink_cnt_r <= 14'h0000;
        blank_r <= ~blank_r;
      end else begin
        blink_cnt_r <= blink_cnt_r + 14'h0001;
      end
    end
  end

  assign row_base = {3'h0, row_r} * 5'h05;
  assign row_bits = {ram_r[row_base + 5'h04][3:0], ram_r[row_base + 5'h03], ram_r[row_base + 5'h02],
                     ram_r[row_base + 5'h01], ram_r[row_base]};
  assign pol = inv_a_r ? frame_par_r : line_par_r;

  // cell voltage is segment xor backplane; blank makes them equal
  always_ff @(posedge mclk) begin
    if (!resetn || !run_r) begin
      segment_out <= 36'h000000000;
      backplane_out <= 4'h0;
    end else begin
      segment_out <= (row_bits & {36{~blank_r}}) ^ {36{~pol}};
      for (int k = 0; k < 4; k++) begin
        if (2'(k) > last_row) begin
          backplane_out[k] <= 1'b0;
        end else begin
          backplane_out[k] <= (2'(k) == row_r) ? ~pol : pol;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      strong_drive_active <= 1'b0;
      bias_half_active <= 1'b0;
    end else begin
      strong_drive_active <= run_r && strong_drive_sel_a_r;
      bias_half_active <= run_r && bias_a_r && mux_a_r != `LCDC_MUX_STATIC;
    end
  end
endmodule

//--- src/lcdc_pkg.sv
// shared types of the lcd control block
package lcdc_pkg;
  typedef logic [7:0] lcdc_byte_t;
  typedef enum logic [1:0] {EVT_CMD, EVT_WDATA, EVT_RADV} lcdc_evt_e;
  typedef enum logic [1:0] {LK_CMD, LK_WRITE, LK_TURN, LK_READ} lcdc_link_e;
endpackage

//--- src/lcdc_spi_link.sv
// 3-line serial port, runs on the serial clock
`timescale 1ns/1ps
module lcdc_spi_link
  import lcdc_pkg::*;
(
  // serial pins
  input wire logic scl,
  input wire logic ce_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  // byte events to the core clock
  output logic evt_toggle,
  output lcdc_evt_e evt_kind,
  output lcdc_byte_t evt_byte,
  // read data, held steady by the core between events
  input wire lcdc_byte_t rd_byte
);
  lcdc_link_e state_r;
  logic [2:0] bit_cnt_r;
  logic [6:0] shift_r;
  lcdc_byte_t tx_r;
  lcdc_byte_t rx;
  logic last_bit;
  // toggle never resets: a reset would fake an event
  logic evt_toggle_r = 1'b0;

  assign rx = {shift_r, sdio_in};
  assign last_bit = (bit_cnt_r == 3'h7);
  assign evt_toggle = evt_toggle_r;

  // frame state ends with chip enable, the clock may stop
  always_ff @(posedge scl or posedge ce_n) begin
    if (ce_n) begin
      state_r <= LK_CMD;
      bit_cnt_r <= 3'h0;
      shift_r <= 7'h00;
    end else begin
      shift_r <= rx[6:0];
      bit_cnt_r <= bit_cnt_r + 3'h1;
      if (last_bit) begin
        case (state_r)
          LK_CMD: state_r <= rx[7] ? LK_TURN : LK_WRITE;
          LK_TURN: state_r <= LK_READ;
          default: state_r <= state_r;
        endcase
      end
    end
  end

  // event byte is stable before its toggle reaches the core
  always_ff @(posedge scl) begin
    if (!ce_n && last_bit) begin
      evt_byte <= rx;
      evt_toggle_r <= ~evt_toggle_r;
      case (state_r)
        LK_CMD: evt_kind <= EVT_CMD;
        LK_WRITE: evt_kind <= EVT_WDATA;
        default: evt_kind <= EVT_RADV;
      endcase
      if (state_r == LK_TURN || state_r == LK_READ) begin
        tx_r <= rd_byte;
      end
    end
  end

  // read data changes on the falling edge, msb first
  always_ff @(negedge scl or posedge ce_n) begin
    if (ce_n) begin
      sdio_out <= 1'b0;
      sdio_oe <= 1'b0;
    end else begin
      sdio_oe <= (state_r == LK_READ);
      sdio_out <= tx_r[3'h7 - bit_cnt_r];
    end
  end
endmodule

//--- verif/lcdc_ctrl_bench.sv
// self-checking bench for the lcd control block
`timescale 1ns/1ps
module lcdc_ctrl_bench;
  import lcdc_pkg::*;
  localparam int H = 2;
  logic mclk, resetn, strap, ext_run, scl, ce_n, host_bit, sdio_out, sdio_oe;
  logic clk_pin_out, clk_pin_oe, strong_drive_active, bias_half_active, regs_undefined, oe_or;
  logic [3:0] backplane_out, bp_or;
  logic [35:0] segment_out;
  logic [1:0] ediv;
  lcdc_byte_t wd [4];
  lcdc_byte_t rq [4];
  lcdc_byte_t masks [4] = '{8'h0F, 8'h07, 8'h03, 8'h01};
  int rates [4] = '{32, 64, 96, 128};
  int err_total, checked, blank_n, n;
  wire logic sdio_in = sdio_oe ? sdio_out : host_bit;
  wire logic [1:0] pr = {segment_out[0] == backplane_out[0], backplane_out[0]};
  wire logic clk_pin_in = ediv[1];
  lcdc_ctrl_top #(.OSC_HALF_CYC(H)) DUT (.mclk(mclk), .resetn(resetn), .power_on_reset_enable_pin(strap),
    .scl(scl), .ce_n(ce_n), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .clk_pin_in(clk_pin_in), .clk_pin_out(clk_pin_out), .clk_pin_oe(clk_pin_oe),
    .backplane_out(backplane_out), .segment_out(segment_out), .strong_drive_active(strong_drive_active),
    .bias_half_active(bias_half_active), .regs_undefined(regs_undefined));
  lcdc_host_model host (.scl(scl), .ce_n(ce_n), .host_bit(host_bit), .sdio_wire(sdio_in));
  initial mclk = 1'b0;
  always #2 mclk = ~mclk;
  // external clock at the same tick rate as the internal oscillator
  always @(negedge mclk) begin
    ediv <= ext_run ? ediv + 2'h1 : 2'h0;
  end
  task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk_byte(input lcdc_byte_t got, input lcdc_byte_t exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: bit %b, wanted %b", $time, got, exp);
    end
  endtask
  task automatic chk_num(input int got, input int exp, input int tol);
    checked++;
    if (got < exp - tol || got > exp + tol) begin
      err_total++;
      $display("unexpected at %0t: count %0d, wanted %0d", $time, got, exp);
    end
  endtask
  task automatic do_reset(input logic s);
    @(negedge mclk);
    strap = s;
    resetn = 1'b0;
    repeat (2) @(negedge mclk);
    resetn = 1'b1;
    repeat (10) @(negedge mclk);
  endtask
  task automatic wr(input logic [4:0] p, input lcdc_byte_t b);
    wd[0] = b;
    host.frame(1'b0, p, 1, wd, rq);
    @(negedge mclk);
  endtask
  task automatic rd(input logic [4:0] p, input lcdc_byte_t e);
    host.frame(1'b1, p, 1, wd, rq);
    @(negedge mclk);
    chk_byte(rq[0], e);
  endtask
  task automatic watch(input int cyc);
    repeat (400) @(negedge mclk);
    bp_or = 4'h0;
    oe_or = 1'b0;
    blank_n = 0;
    repeat (cyc) begin
      @(negedge mclk);
      bp_or = bp_or | backplane_out;
      oe_or = oe_or | clk_pin_oe;
      if (pr[1]) blank_n++;
    end
  endtask
  // cycles until the chosen probe next changes level
  task automatic gap(input logic sel, output int cnt);
    logic v;
    cnt = 0;
    v = pr[sel];
    while (pr[sel] === v && cnt < 50000) begin
      @(negedge mclk);
      cnt++;
    end
  endtask
  initial begin
    resetn = 1'b0;
    strap = 1'b0;
    ext_run = 1'b0;
    err_total = 0;
    checked = 0;
    do_reset(1'b0);
    chk_bit(regs_undefined, 1'b1);
    wr(5'h01, 8'h08);
    rd(5'h01, 8'h04);
    wr(5'h00, 8'h2C);
    chk_bit(regs_undefined, 1'b0);
    rd(5'h00, 8'h00);
    do_reset(1'b1);
    chk_bit(regs_undefined, 1'b0);
    rd(5'h01, 8'h04);
    rd(5'h02, 8'h00);
    rd(5'h03, 8'h00);
    wd = '{8'h09, 8'h1A, 8'h07, 8'h00};
    host.frame(1'b0, 5'h01, 3, wd, rq);
    host.frame(1'b1, 5'h01, 3, wd, rq);
    for (int i = 0; i < 3; i++) chk_byte(rq[i], wd[i]);
    chk_byte({4'h0, backplane_out}, 8'h00);
    wd = '{8'hAA, 8'h0A, 8'h33, 8'h00};
    host.frame(1'b0, 5'h16, 3, wd, rq);
    host.frame(1'b1, 5'h16, 3, wd, rq);
    chk_byte(rq[0], 8'hAA);
    chk_byte(rq[1], 8'h0A);
    chk_byte(rq[2], 8'h00);
    wr(5'h03, 8'h00);
    wr(5'h01, 8'h0C);
    wr(5'h02, 8'h0D);
    watch(300);
    chk_bit(oe_or, 1'b0);
    chk_bit(|bp_or, 1'b1);
    wr(5'h01, 8'h0D);
    watch(300);
    chk_bit(oe_or, 1'b1);
    wr(5'h03, 8'h01);
    for (int m = 0; m < 4; m++) begin
      wr(5'h02, {3'h0, m[0], m[1:0], 2'h3});
      watch(600);
      chk_byte({4'h0, bp_or}, masks[m]);
      chk_bit(strong_drive_active, m[0]);
      chk_bit(bias_half_active, m != 3);
    end
    wr(5'h03, 8'h00);
    for (int f = 0; f < 4; f++) begin
      wr(5'h01, {4'h0, f[1:0], 2'h1});
      gap(1'b0, n);
      gap(1'b0, n);
      chk_num(n, 9216 / rates[f] * 2 * H, 2);
    end
    // two rows, frame inversion: backplane 0 flips once per frame
    wr(5'h03, 8'h01);
    wr(5'h02, 8'h09);
    repeat (4) gap(1'b0, n);
    chk_num(n, 9216 / 128 * 2 * H, 2);
    wr(5'h02, 8'h0D);
    wr(5'h04, 8'hFF);
    watch(600);
    chk_num(blank_n, 0, 0);
    wr(5'h03, 8'h06);
    gap(1'b1, n);
    gap(1'b1, n);
    gap(1'b1, n);
    chk_num(n, 9216000 / 4000 * 2 * H, 8);
    for (int b = 1; b < 3; b++) begin
      wr(5'h03, {5'h0, b[1:0], 1'b0});
      rd(5'h03, {5'h0, b[1:0], 1'b0});
    end
    wr(5'h02, 8'h00);
    watch(300);
    chk_bit(oe_or | (|bp_or) | strong_drive_active, 1'b0);
    wr(5'h01, 8'h0E);
    ext_run = 1'b1;
    wr(5'h02, 8'h0D);
    watch(600);
    chk_bit(|bp_or, 1'b1);
    chk_bit(oe_or, 1'b0);
    wr(5'h02, 8'h00);
    watch(10);
    ext_run = 1'b0;
    wr(5'h00, 8'h2C);
    rd(5'h01, 8'h04);
    rd(5'h03, 8'h00);
    rd(5'h04, 8'h00);
    print_verdict;
  end
  initial begin
    repeat (90000) @(posedge mclk);
    err_total++;
    $display("unexpected at %0t: watchdog expired", $time);
    print_verdict;
  end
endmodule
bind lcdc_ctrl_top lcdc_ctrl_props #(.OSC_HALF_CYC(OSC_HALF_CYC)) props (.mclk(mclk), .resetn(resetn),
  .power_on_reset_enable_pin(power_on_reset_enable_pin), .ce_n(ce_n), .sdio_oe(sdio_oe),
  .clk_pin_out(clk_pin_out), .clk_pin_oe(clk_pin_oe), .backplane_out(backplane_out),
  .segment_out(segment_out), .strong_drive_active(strong_drive_active),
  .bias_half_active(bias_half_active), .regs_undefined(regs_undefined));

//--- verif/lcdc_ctrl_props.sv
// concurrent checks on the lcd control block ports
`timescale 1ns/1ps
module lcdc_ctrl_props #(
  parameter int unsigned OSC_HALF_CYC = 2
) (
  // clock, reset, strap
  input wire logic mclk,
  input wire logic resetn,
  input wire logic power_on_reset_enable_pin,
  // serial and clock pin
  input wire logic ce_n,
  input wire logic sdio_oe,
  input wire logic clk_pin_out,
  input wire logic clk_pin_oe,
  // display drive
  input wire logic [3:0] backplane_out,
  input wire logic [35:0] segment_out,
  input wire logic strong_drive_active,
  input wire logic bias_half_active,
  input wire logic regs_undefined
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic prev_out;
  int unsigned run_len;
  int unsigned oe_len;
  // length of the level now standing on the clock pin
  always_ff @(posedge mclk) begin
    prev_out <= clk_pin_out;
    if (!resetn) begin
      run_len <= 0;
    end else if (clk_pin_out != prev_out) begin
      run_len <= 1;
    end else begin
      run_len <= run_len + 1;
    end
  end
  // first runs after enable may be partial, so they are skipped
  always_ff @(posedge mclk) begin
    if (!resetn || !clk_pin_oe) begin
      oe_len <= 0;
    end else if (oe_len < 1000000) begin
      oe_len <= oe_len + 1;
    end
  end
  chk_reset_quiet: assert property ($rose(resetn) |-> segment_out == 36'h0 && regs_undefined)
    else $error("outputs not cleared by reset");
  chk_release_idle: assert property ($rose(resetn) |-> (backplane_out == 4'h0 && !clk_pin_oe) [*8])
    else $error("display active right after reset");
  chk_strap_define: assert property ($rose(resetn) && power_on_reset_enable_pin |-> ##[1:8] !regs_undefined)
    else $error("strap did not define registers");
  chk_undef_quiet: assert property (regs_undefined |-> backplane_out == 4'h0 && !clk_pin_oe
    && !strong_drive_active && !bias_half_active) else $error("display runs on undefined registers");
  chk_undef_source: assert property ($rose(regs_undefined) |-> !$past(resetn))
    else $error("undefined flag rose without reset");
  chk_clk_half: assert property (clk_pin_oe && oe_len > 2 * OSC_HALF_CYC + 1 && clk_pin_out != prev_out
    |-> run_len == OSC_HALF_CYC) else $error("clock pin half period wrong");
  chk_clk_alive: assert property (clk_pin_oe && oe_len > 2 * OSC_HALF_CYC + 1 |-> run_len <= OSC_HALF_CYC)
    else $error("clock pin stuck while driven");
  chk_sdio_quiet: assert property (ce_n |-> !sdio_oe)
    else $error("data pin driven while deselected");
  cover property ($rose(clk_pin_oe));
  cover property ($fell(regs_undefined));
  cover property ($rose(sdio_oe));
endmodule

//--- verif/lcdc_host_model.sv
// host side of the 3-line serial port
`timescale 1ns/1ps
module lcdc_host_model
  import lcdc_pkg::*;
(
  // serial pins
  output logic scl,
  output logic ce_n,
  output logic host_bit,
  input wire logic sdio_wire
);
  initial begin
    scl = 1'b0;
    ce_n = 1'b1;
    host_bit = 1'b0;
  end
  // a released line shows the inverse of its last level, never a held value
  task automatic shift(input lcdc_byte_t tx, input logic drv, output lcdc_byte_t rx);
    for (int i = 7; i >= 0; i--) begin
      host_bit = drv ? tx[i] : ~host_bit;
      #3 scl = 1'b1;
      rx[i] = sdio_wire;
      #3 scl = 1'b0;
    end
  endtask
  task automatic frame(input logic rd_op, input logic [4:0] ptr, input int n,
                       input lcdc_byte_t wd [4], output lcdc_byte_t rq [4]);
    lcdc_byte_t junk;
    ce_n = 1'b0;
    #5;
    shift({rd_op, 2'b00, ptr}, 1'b1, junk);
    if (rd_op) shift(8'h00, 1'b0, junk);
    for (int k = 0; k < n; k++) shift(wd[k], !rd_op, rq[k]);
    #5 ce_n = 1'b1;
    host_bit = ~host_bit;
    #40;
  endtask
endmodule
